// [irq_pkg.sv]
// Shared constants for the single-vector interrupt unit and its CPU end.
// Assumes one clock, clk_sys at 10 MHz, synchronous active-high reset.
`default_nettype none
package irq_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SRC = 4;
  // Register offsets
  localparam logic [7:0] TIMER_ZERO_CONTROL_ADDR = 8'hd2;
  localparam logic [7:0] SYSTEM_MODE_ADDR = 8'hdf;
  localparam logic [7:0] PULSE_WIDTH_CONTROL_ADDR = 8'hf3;
  localparam logic [7:0] PORT_ZERO_PEND_ADDR = 8'he8;
  // Register reset values
  localparam logic [7:0] TIMER_ZERO_CONTROL_RST = 8'h00;
  localparam logic [7:0] SYSTEM_MODE_RST = 8'h00;
  localparam logic [7:0] PULSE_WIDTH_CONTROL_RST = 8'h00;
  localparam logic [7:0] PORT_ZERO_PEND_RST = 8'h00;
  // Field positions
  localparam int unsigned GIE_BIT = 3;
  localparam int unsigned CTRL_PEND_BIT = 0;
  localparam int unsigned CTRL_EN_BIT = 1;
  localparam int unsigned CTRL_CLR_BIT = 3;
  localparam int unsigned PIN0_PEND_BIT = 0;
  localparam int unsigned PIN0_EN_BIT = 1;
  localparam int unsigned PIN1_PEND_BIT = 2;
  localparam int unsigned PIN1_EN_BIT = 3;
  // Writable masks: unused bits read as zero
  localparam logic [7:0] TIMER_ZERO_MASK = 8'hcb;
  localparam logic [7:0] PULSE_WIDTH_MASK = 8'hdf;
  localparam logic [7:0] SYSTEM_MODE_MASK = 8'h0f;
  localparam logic [7:0] PORT_ZERO_MASK = 8'h0f;
  // Source indices
  localparam int unsigned SRC_PWM = 0;
  localparam int unsigned SRC_TMR = 1;
  localparam int unsigned SRC_PIN0 = 2;
  localparam int unsigned SRC_PIN1 = 3;
  // Vector location
  localparam logic [15:0] VECTOR_HI_ADDR = 16'h0000;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'h0001;
  // Interrupt machine cycle steps (memory side)
  typedef enum logic [2:0] {
    STEP_PUSH_PCL,
    STEP_PUSH_PCH,
    STEP_PUSH_FLAGS,
    STEP_FETCH_HI,
    STEP_FETCH_LO,
    STEP_POP_FLAGS,
    STEP_POP_PCH,
    STEP_POP_PCL
  } step_e;
endpackage
`default_nettype wire

// [irq_if.sv]
// Link between the interrupt unit (device) and the CPU-side sequencer.
// Assumes both ends share clk_sys.
`default_nettype none
interface irq_if;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq_req;
  logic irq_ack;
  logic irq_ret;
  logic gie;
  modport device (
    input reg_addr, reg_wdata, reg_wr, reg_rd, irq_ack, irq_ret,
    output reg_rdata, irq_req, gie
  );
  modport cpu (
    output reg_addr, reg_wdata, reg_wr, reg_rd, irq_ack, irq_ret,
    input reg_rdata, irq_req, gie
  );
endinterface
`default_nettype wire

// [fall_edge_det.sv]
// Falling-edge detector for one external interrupt pin.
// Assumes the pin is already synchronous to clk_sys.
`default_nettype none
module fall_edge_det (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin,
  output logic fell
);
  logic last_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      last_q <= 1'b1;
    end else begin
      last_q <= pin;
    end
  end
  assign fell = last_q & ~pin;
endmodule
`default_nettype wire

// [irq_unit.sv]
// Interrupt unit: enables, pending flags, global enable, combined request.
// Assumes a CPU end on irq_if that acknowledges and returns.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
// Contract
// - Exactly four sources: PWM, timer, two pins
// - All sources share vector at 0000H
// - Global enable bit three gates everything
// - Ack needs global and source enable
// - Acceptance clears the global enable first
// - Push PC low, PC high, flags
// - Fetch vector high then low, branch
// - Return restores and sets global enable
// - Source request sets its pending bit
// - CPU raises acknowledge on acceptance
// - Handler clears pending before return
// - No priority; software polls pending bits
// - Init code enables interrupts after reset
// - Timer control bit one enables match
// - Timer pending: write zero clears only
// - PWM control bit one enables overflow
// - PWM pending: write zero clears only
// - Timer bit three clears timer counter
// - PWM bit three clears PWM counter
// - Pin enable bits allow falling edges
// - Pin pending: write zero clears only
module irq_unit (
  input wire logic clk_sys,
  input wire logic sys_rst,
  irq_if.device bus,
  input wire logic pwm_overflow,
  input wire logic timer_match,
  input wire logic ext_pin_irq_zero,
  input wire logic ext_pin_irq_one,
  output logic timer_counter_clear,
  output logic pulse_counter_clear
);
  logic [7:0] timer_zero_ctrl_q;
  logic [7:0] pulse_width_ctrl_q;
  logic [7:0] system_mode_reg_q;
  logic [7:0] port_zero_pend_reg_q;
  logic [7:0] rdata_q;
  logic req_q;
  logic pin0_fell;
  logic pin1_fell;
  logic [3:0] pend;
  logic [3:0] en;
  logic wr_tmr;
  logic wr_pwm;
  logic wr_sym;
  logic wr_p0;
  logic [3:0] pend_d;
  logic [3:0] en_d;
  logic gie_d;

  // Write-zero clears a pending bit; hardware set wins.
  function automatic logic pend_next(input logic cur, input logic set,
                                     input logic wr, input logic wbit);
    pend_next = set | (cur & ~(wr & ~wbit));
  endfunction

  fall_edge_det u_pin0 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(ext_pin_irq_zero),
    .fell(pin0_fell)
  );
  fall_edge_det u_pin1 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(ext_pin_irq_one),
    .fell(pin1_fell)
  );

  assign wr_tmr = bus.reg_wr &&
    bus.reg_addr == irq_pkg::TIMER_ZERO_CONTROL_ADDR;
  assign wr_pwm = bus.reg_wr &&
    bus.reg_addr == irq_pkg::PULSE_WIDTH_CONTROL_ADDR;
  assign wr_sym = bus.reg_wr && bus.reg_addr == irq_pkg::SYSTEM_MODE_ADDR;
  assign wr_p0 = bus.reg_wr && bus.reg_addr == irq_pkg::PORT_ZERO_PEND_ADDR;

  // Timer control
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      timer_zero_ctrl_q <= irq_pkg::TIMER_ZERO_CONTROL_RST;
    end else begin
      if (wr_tmr) begin
        timer_zero_ctrl_q <=
          bus.reg_wdata & irq_pkg::TIMER_ZERO_MASK;
      end
      timer_zero_ctrl_q[irq_pkg::CTRL_PEND_BIT] <=
        pend_d[irq_pkg::SRC_TMR];
    end
  end

  // PWM control
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pulse_width_ctrl_q <= irq_pkg::PULSE_WIDTH_CONTROL_RST;
    end else begin
      if (wr_pwm) begin
        pulse_width_ctrl_q <=
          bus.reg_wdata & irq_pkg::PULSE_WIDTH_MASK;
      end
      pulse_width_ctrl_q[irq_pkg::CTRL_PEND_BIT] <=
        pend_d[irq_pkg::SRC_PWM];
    end
  end

  // Port 0 pin pending and enables
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port_zero_pend_reg_q <= irq_pkg::PORT_ZERO_PEND_RST;
    end else begin
      if (wr_p0) begin
        port_zero_pend_reg_q[irq_pkg::PIN0_EN_BIT] <=
          bus.reg_wdata[irq_pkg::PIN0_EN_BIT];
        port_zero_pend_reg_q[irq_pkg::PIN1_EN_BIT] <=
          bus.reg_wdata[irq_pkg::PIN1_EN_BIT];
      end
      port_zero_pend_reg_q[irq_pkg::PIN0_PEND_BIT] <=
        pend_d[irq_pkg::SRC_PIN0];
      port_zero_pend_reg_q[irq_pkg::PIN1_PEND_BIT] <=
        pend_d[irq_pkg::SRC_PIN1];
    end
  end

  // System mode: global enable and page bits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      system_mode_reg_q <= irq_pkg::SYSTEM_MODE_RST;
    end else begin
      if (wr_sym) begin
        system_mode_reg_q <=
          bus.reg_wdata & irq_pkg::SYSTEM_MODE_MASK;
      end
      system_mode_reg_q[irq_pkg::GIE_BIT] <= gie_d;
    end
  end

  // Four sources, no priority among them
  assign pend = {port_zero_pend_reg_q[irq_pkg::PIN1_PEND_BIT],
                 port_zero_pend_reg_q[irq_pkg::PIN0_PEND_BIT],
                 timer_zero_ctrl_q[irq_pkg::CTRL_PEND_BIT],
                 pulse_width_ctrl_q[irq_pkg::CTRL_PEND_BIT]};
  assign en = {port_zero_pend_reg_q[irq_pkg::PIN1_EN_BIT],
               port_zero_pend_reg_q[irq_pkg::PIN0_EN_BIT],
               timer_zero_ctrl_q[irq_pkg::CTRL_EN_BIT],
               pulse_width_ctrl_q[irq_pkg::CTRL_EN_BIT]};

  // Next state of every request term; the flags load from it
  always_comb begin
    pend_d[irq_pkg::SRC_PWM] = pend_next(pend[irq_pkg::SRC_PWM],
      pwm_overflow, wr_pwm,
      bus.reg_wdata[irq_pkg::CTRL_PEND_BIT]);
    pend_d[irq_pkg::SRC_TMR] = pend_next(pend[irq_pkg::SRC_TMR],
      timer_match, wr_tmr,
      bus.reg_wdata[irq_pkg::CTRL_PEND_BIT]);
    pend_d[irq_pkg::SRC_PIN0] = pend_next(pend[irq_pkg::SRC_PIN0],
      pin0_fell & en[irq_pkg::SRC_PIN0], wr_p0,
      bus.reg_wdata[irq_pkg::PIN0_PEND_BIT]);
    pend_d[irq_pkg::SRC_PIN1] = pend_next(pend[irq_pkg::SRC_PIN1],
      pin1_fell & en[irq_pkg::SRC_PIN1], wr_p0,
      bus.reg_wdata[irq_pkg::PIN1_PEND_BIT]);
    en_d = en;
    if (wr_pwm) begin
      en_d[irq_pkg::SRC_PWM] = bus.reg_wdata[irq_pkg::CTRL_EN_BIT];
    end
    if (wr_tmr) begin
      en_d[irq_pkg::SRC_TMR] = bus.reg_wdata[irq_pkg::CTRL_EN_BIT];
    end
    if (wr_p0) begin
      en_d[irq_pkg::SRC_PIN0] = bus.reg_wdata[irq_pkg::PIN0_EN_BIT];
      en_d[irq_pkg::SRC_PIN1] = bus.reg_wdata[irq_pkg::PIN1_EN_BIT];
    end
    // Acceptance beats return, both beat a software write
    if (bus.irq_ack) begin
      gie_d = 1'b0;
    end else if (bus.irq_ret) begin
      gie_d = 1'b1;
    end else if (wr_sym) begin
      gie_d = bus.reg_wdata[irq_pkg::GIE_BIT];
    end else begin
      gie_d = system_mode_reg_q[irq_pkg::GIE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      req_q <= 1'b0;
    end else begin
      // From next state, so a disabling write is never a cycle late
      req_q <= |(pend_d & en_d) && gie_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (bus.reg_rd) begin
      if (bus.reg_addr == irq_pkg::TIMER_ZERO_CONTROL_ADDR) begin
        rdata_q <= timer_zero_ctrl_q;
      end else if (bus.reg_addr == irq_pkg::PULSE_WIDTH_CONTROL_ADDR) begin
        rdata_q <= pulse_width_ctrl_q;
      end else if (bus.reg_addr == irq_pkg::SYSTEM_MODE_ADDR) begin
        rdata_q <= system_mode_reg_q;
      end else if (bus.reg_addr == irq_pkg::PORT_ZERO_PEND_ADDR) begin
        rdata_q <= port_zero_pend_reg_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign bus.reg_rdata = rdata_q;
  assign bus.irq_req = req_q;
  assign bus.gie = system_mode_reg_q[irq_pkg::GIE_BIT];
  // Level while the bit stays written as 1
  assign timer_counter_clear =
    timer_zero_ctrl_q[irq_pkg::CTRL_CLR_BIT];
  assign pulse_counter_clear =
    pulse_width_ctrl_q[irq_pkg::CTRL_CLR_BIT];
endmodule
`default_nettype wire

// [irq_cpu_seq.sv]
// CPU-side interrupt sequencer: accepts requests at instruction end, runs
// the interrupt machine cycle and the return; forwards software accesses.
// Assumes a memory port answering reads in the cycle after mem_rd.
`default_nettype none
module irq_cpu_seq (
  input wire logic clk_sys,
  input wire logic sys_rst,
  irq_if.cpu link,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  input wire logic instr_end,
  input wire logic ret_instr,
  input wire logic [15:0] pc,
  input wire logic [7:0] flags,
  output logic busy,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] new_pc,
  output logic [7:0] new_flags,
  output logic load_pc
);
  typedef enum logic [3:0] {
    S_IDLE, S_PCL, S_PCH, S_FLG, S_VHI, S_VLO, S_JUMP,
    S_RFLG, S_RPCH, S_RPCL, S_RDONE
  } st_e;
  st_e st_q;
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic busy_q;
  logic ack_q;
  logic ret_q;
  logic [15:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic mem_wr_q;
  logic mem_rd_q;
  logic load_q;

  // Sequence: stack is external memory; stack accesses address step codes, vector fetch addresses 0000H and 0001H.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      pc_q <= 16'h0000;
      flags_q <= 8'h00;
      busy_q <= 1'b0;
      ack_q <= 1'b0;
      ret_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 8'h00;
      mem_wr_q <= 1'b0;
      mem_rd_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      ret_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_rd_q <= 1'b0;
      load_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (instr_end && link.irq_req && !ack_q) begin
            ack_q <= 1'b1;
            busy_q <= 1'b1;
            pc_q <= pc;
            flags_q <= flags;
            mem_addr_q <= 16'(irq_pkg::STEP_PUSH_PCL);
            mem_wdata_q <= pc[7:0];
            mem_wr_q <= 1'b1;
            st_q <= S_PCL;
          end else if (ret_instr) begin
            busy_q <= 1'b1;
            mem_addr_q <= 16'(irq_pkg::STEP_POP_FLAGS);
            mem_rd_q <= 1'b1;
            st_q <= S_RFLG;
          end
        end
        S_PCL: begin
          mem_addr_q <= 16'(irq_pkg::STEP_PUSH_PCH);
          mem_wdata_q <= pc_q[15:8];
          mem_wr_q <= 1'b1;
          st_q <= S_PCH;
        end
        S_PCH: begin
          mem_addr_q <= 16'(irq_pkg::STEP_PUSH_FLAGS);
          mem_wdata_q <= flags_q;
          mem_wr_q <= 1'b1;
          st_q <= S_FLG;
        end
        S_FLG: begin
          mem_addr_q <= irq_pkg::VECTOR_HI_ADDR;
          mem_rd_q <= 1'b1;
          st_q <= S_VHI;
        end
        S_VHI: begin
          mem_addr_q <= irq_pkg::VECTOR_LO_ADDR;
          mem_rd_q <= 1'b1;
          st_q <= S_VLO;
        end
        S_VLO: begin
          pc_q[15:8] <= mem_rdata;
          st_q <= S_JUMP;
        end
        S_JUMP: begin
          pc_q[7:0] <= mem_rdata;
          load_q <= 1'b1;
          busy_q <= 1'b0;
          st_q <= S_IDLE;
        end
        S_RFLG: begin
          mem_addr_q <= 16'(irq_pkg::STEP_POP_PCH);
          mem_rd_q <= 1'b1;
          st_q <= S_RPCH;
        end
        S_RPCH: begin
          flags_q <= mem_rdata;
          mem_addr_q <= 16'(irq_pkg::STEP_POP_PCL);
          mem_rd_q <= 1'b1;
          st_q <= S_RPCL;
        end
        S_RPCL: begin
          pc_q[15:8] <= mem_rdata;
          st_q <= S_RDONE;
        end
        S_RDONE: begin
          pc_q[7:0] <= mem_rdata;
          load_q <= 1'b1;
          ret_q <= 1'b1;
          busy_q <= 1'b0;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  assign link.reg_addr = sw_addr;
  assign link.reg_wdata = sw_wdata;
  assign link.reg_wr = sw_wr;
  assign link.reg_rd = sw_rd;
  assign link.irq_ack = ack_q;
  assign link.irq_ret = ret_q;
  // Read data stands in the cycle after the strobe, as on the link
  assign sw_rdata = link.reg_rdata;
  assign busy = busy_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign mem_wr = mem_wr_q;
  assign mem_rd = mem_rd_q;
  assign new_pc = pc_q;
  assign new_flags = flags_q;
  assign load_pc = load_q;
endmodule
`default_nettype wire

// [single_vector_interrupt_unit_sva.sv]
// Checker on the irq_if link between the unit and the CPU sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module single_vector_interrupt_unit_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_req,
  input wire logic irq_ack,
  input wire logic irq_ret,
  input wire logic gie
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sym_sel;
  logic wbit;
  logic gie_cause;
  assign sym_sel = reg_addr == irq_pkg::SYSTEM_MODE_ADDR;
  assign wbit = reg_wdata[irq_pkg::GIE_BIT];
  assign gie_cause = irq_ack | irq_ret | (reg_wr & sym_sel);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_gie_rst; $fell(sys_rst) |-> !gie; endproperty
  a_gie_rst: assert property (p_gie_rst)
    else $error("global enable set after reset");
  property p_gie_wr;
    reg_wr && sym_sel && !irq_ack && !irq_ret |=> gie == $past(wbit);
  endproperty
  a_gie_wr: assert property (p_gie_wr)
    else $error("global enable does not follow write");
  property p_sym_rd;
    reg_rd && sym_sel |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3] == $past(gie);
  endproperty
  a_sym_rd: assert property (p_sym_rd)
    else $error("system mode read wrong");
  property p_gie_cause; $changed(gie) |-> $past(gie_cause); endproperty
  a_gie_cause: assert property (p_gie_cause)
    else $error("global enable changed without cause");
  property p_req_gie; irq_req |-> gie; endproperty
  a_req_gie: assert property (p_req_gie)
    else $error("request without global enable");
  property p_ack_req; irq_ack |-> $past(irq_req); endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("acknowledge without request");
  property p_ack_pulse; irq_ack |=> !irq_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  property p_ack_gie; irq_ack |=> !gie ##1 !irq_req; endproperty
  a_ack_gie: assert property (p_ack_gie)
    else $error("acceptance left global enable set");
  property p_ack_drop; irq_ack |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request still up after acknowledge");
  property p_ret_gie; irq_ret && !irq_ack |=> gie; endproperty
  a_ret_gie: assert property (p_ret_gie)
    else $error("return did not set global enable");
endmodule
`default_nettype wire

// [single_vector_interrupt_unit_tb.sv]
// Bench joining unit and sequencer over irq_if, with a memory model.
// Assumes the package, interface and both design modules compiled first.
`default_nettype none
module single_vector_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic sw_wr = 1'b0, sw_rd = 1'b0, instr_end = 1'b0, ret_instr = 1'b0;
  logic pwm_ov = 1'b0, tmr_m = 1'b0, pin0 = 1'b1, pin1 = 1'b1;
  logic [7:0] sw_addr = 8'h00, sw_wdata = 8'h00, flags = 8'h00;
  logic [7:0] mem_rdata = 8'h00, sw_rdata, mem_wdata, new_flags;
  logic [15:0] pc = 16'h0000, vec = 16'h0000, mem_addr, new_pc;
  logic busy, mem_wr, mem_rd, load_pc, tcc, pcc;
  logic [7:0] ra[5] = '{8'hd2, 8'hdf, 8'hf3, 8'he8, 8'h00};
  logic [7:0] ad[4] = '{8'hf3, 8'hd2, 8'he8, 8'he8};
  logic [7:0] pm[4] = '{8'h01, 8'h01, 8'h01, 8'h04};
  logic [7:0] em[4] = '{8'h02, 8'h02, 8'h02, 8'h08};
  logic [7:0] wq[$];
  logic [15:0] rq[$];
  int num_errors = 0, checks = 0, cyc = 0, acks = 0, seed;
  irq_if ifc ();
  always #50 clk_sys = ~clk_sys;
  irq_unit irq_unit_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(ifc),
    .pwm_overflow(pwm_ov), .timer_match(tmr_m), .ext_pin_irq_zero(pin0),
    .ext_pin_irq_one(pin1), .timer_counter_clear(tcc),
    .pulse_counter_clear(pcc));
  irq_cpu_seq irq_cpu_seq_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(ifc), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .instr_end(instr_end),
    .ret_instr(ret_instr), .pc(pc), .flags(flags), .busy(busy),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .new_pc(new_pc),
    .new_flags(new_flags), .load_pc(load_pc));
  single_vector_interrupt_unit_sva single_vector_interrupt_unit_sva_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(ifc.reg_addr),
    .reg_wdata(ifc.reg_wdata), .reg_wr(ifc.reg_wr), .reg_rd(ifc.reg_rd),
    .reg_rdata(ifc.reg_rdata), .irq_req(ifc.irq_req),
    .irq_ack(ifc.irq_ack), .irq_ret(ifc.irq_ret), .gie(ifc.gie));
  // Memory: vector at 0 and 1, stack pops at 5 to 7, else changing data
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (ifc.irq_ack) acks <= acks + 1;
    if (mem_wr) wq.push_back(mem_wdata);
    if (mem_rd) rq.push_back(mem_addr);
    case (mem_rd ? mem_addr : 16'hffff)
      16'h0000: mem_rdata <= vec[15:8];
      16'h0001: mem_rdata <= vec[7:0];
      16'h0005: mem_rdata <= wq[2];
      16'h0006: mem_rdata <= wq[1];
      16'h0007: mem_rdata <= wq[0];
      default: mem_rdata <= ~mem_rdata;
    endcase
    if (cyc > 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1;
    chk({8'h00, sw_rdata}, {8'h00, exp});
  endtask
  task automatic trig(input int i);
    @(posedge clk_sys);
    case (i)
      0: pwm_ov <= 1'b1;
      1: tmr_m <= 1'b1;
      2: pin0 <= 1'b0;
      default: pin1 <= 1'b0;
    endcase
    @(posedge clk_sys);
    pwm_ov <= 1'b0;
    tmr_m <= 1'b0;
    repeat (3) @(posedge clk_sys);
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    #1;
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    #1;
    while (load_pc !== 1'b1 && n < 30) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk({15'h0000, load_pc}, 16'h0001);
  endtask
  task automatic wrap_up();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    seed = $urandom(32'h60bd);
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (ra[k]) rd(ra[k], 8'h00);
    $display("test reset done");
    wr(8'hd2, 8'hff);
    chk({15'h0000, tcc}, 16'h0001);
    rd(8'hd2, irq_pkg::TIMER_ZERO_MASK & 8'hfe);
    wr(8'hf3, 8'hff);
    chk({15'h0000, pcc}, 16'h0001);
    rd(8'hf3, irq_pkg::PULSE_WIDTH_MASK & 8'hfe);
    wr(8'hd2, 8'h00);
    wr(8'hf3, 8'h00);
    chk({14'h0000, tcc, pcc}, 16'h0000);
    trig(3);
    rd(8'he8, 8'h00);
    $display("test control done");
    wr(8'hd2, 8'h02);
    trig(1);
    @(posedge clk_sys);
    instr_end <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(acks[15:0], 16'h0000);
    wr(8'hd2, 8'h01);
    rd(8'hd2, 8'h01);
    wr(8'hdf, 8'h08);
    repeat (10) @(posedge clk_sys);
    chk(acks[15:0], 16'h0000);
    wr(8'hdf, 8'h00);
    wr(8'hd2, 8'h00);
    rd(8'hd2, 8'h00);
    $display("test gating done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      instr_end <= 1'b0;
      pc <= 16'($urandom());
      flags <= 8'($urandom());
      vec <= 16'($urandom());
      wr(ad[i], em[i] | pm[i]);
      rd(ad[i], em[i]);
      trig(i);
      rd(ad[i], em[i] | pm[i]);
      wq.delete();
      rq.delete();
      wr(8'hdf, 8'h08);
      @(posedge clk_sys);
      instr_end <= 1'b1;
      wait_load();
      chk(new_pc, vec);
      chk({15'h0000, busy}, 16'h0000);
      chk({8'h00, wq[0]}, {8'h00, pc[7:0]});
      chk({8'h00, wq[1]}, {8'h00, pc[15:8]});
      chk({8'h00, wq[2]}, {8'h00, flags});
      chk(rq[0], 16'h0000);
      chk(rq[1], 16'h0001);
      @(posedge clk_sys);
      instr_end <= 1'b0;
      rd(8'hdf, 8'h00);
      wr(ad[i], em[i]);
      rd(ad[i], em[i]);
      @(posedge clk_sys);
      ret_instr <= 1'b1;
      @(posedge clk_sys);
      ret_instr <= 1'b0;
      wait_load();
      chk(new_pc, pc);
      chk({8'h00, new_flags}, {8'h00, flags});
      chk(rq[4], 16'h0007);
      rd(8'hdf, 8'h08);
      wr(8'hdf, 8'h00);
      wr(ad[i], 8'h00);
      $display("test source %0d done", i);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
